// ===== inc/tlic_pkg.sv
// Package for the two-level interrupt controller: register map, field positions,
// reset values and vector addresses.
// Assumes a single clock domain and an AXI4-Lite register bus with 32-bit data.
package tlic_pkg;

   // ----------------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------------
   localparam int unsigned NUM_SRC  = 16;
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned DATA_W   = 32;

   // ----------------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] CONTROL_OFS  = 8'h00;
   localparam logic [ADDR_W-1:0] FLAG_OFS     = 8'h04;
   localparam logic [ADDR_W-1:0] ENABLE_OFS   = 8'h08;
   localparam logic [ADDR_W-1:0] PRIORITY_OFS = 8'h0C;
   localparam logic [ADDR_W-1:0] STATUS_OFS   = 8'h10;

   // ----------------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------------
   localparam int unsigned CTL_MODE_BIT = 0;
   localparam int unsigned CTL_GH_BIT   = 1;
   localparam int unsigned CTL_GL_BIT   = 2;

   // ----------------------------------------------------------------------
   // Status register fields (read only)
   // ----------------------------------------------------------------------
   localparam int unsigned STS_HIGH_ACT_BIT = 0;
   localparam int unsigned STS_LOW_ACT_BIT  = 1;
   localparam int unsigned STS_REQ_BIT      = 2;
   localparam int unsigned STS_VEC_LSB      = 16;

   // ----------------------------------------------------------------------
   // Sources, vectors and reset values
   // ----------------------------------------------------------------------
   localparam logic [NUM_SRC-1:0] EXT_ZERO_MASK = 16'h0001;
   localparam logic [NUM_SRC-1:0] PERIPH_MASK   = 16'hFFF0;
   localparam logic [15:0]        HIGH_VECTOR   = 16'h0008;
   localparam logic [15:0]        LOW_VECTOR    = 16'h0018;
   localparam logic [NUM_SRC-1:0] FLAG_RST      = 16'h0000;
   localparam logic [NUM_SRC-1:0] ENABLE_RST    = 16'h0000;
   localparam logic [NUM_SRC-1:0] PRIORITY_RST  = 16'hFFFF;

   // ----------------------------------------------------------------------
   // AXI responses
   // ----------------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------------
   // Whole state of the controller
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic               mode;
      logic               gh;
      logic               gl;
      logic [NUM_SRC-1:0] flag;
      logic [NUM_SRC-1:0] en;
      logic [NUM_SRC-1:0] prio;
      logic               high_act;
      logic               low_act;
      logic               req;
      logic               vec_high;
      logic [15:0]        vector;
      logic               awready;
      logic               wready;
      logic               aw_got;
      logic               w_got;
      logic [ADDR_W-1:0]  awaddr;
      logic [DATA_W-1:0]  wdata;
      logic [3:0]         wstrb;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               arready;
      logic               rvalid;
      logic [1:0]         rresp;
      logic [DATA_W-1:0]  rdata;
   } tlic_state_type;

endpackage

// ===== hdl/tlic_core.sv
// Two-level interrupt controller: flag, enable and priority bits per source,
// compatibility or two-level arbitration, and vector selection for the core.
// Assumes the core pulses irq_ack when it takes the vector and pulses
// return_from_handler when a handler returns; both synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none

module tlic_core
   import tlic_pkg::*;
(
   input  wire logic               aclk,                // 40 MHz clock
   input  wire logic               aresetn,             // Synchronous reset, low
   input  wire logic [NUM_SRC-1:0] src_event,           // Source event pulses
   input  wire logic               irq_ack,             // Core takes the vector
   input  wire logic               return_from_handler, // Handler return pulse
   output var  logic               irq_request,         // Branch request to core
   output var  logic [15:0]        irq_vector,          // Vector address
   output var  logic               irq_level_high,      // Request is high level
   input  wire logic [ADDR_W-1:0]  s_axi_awaddr,        // Write address
   input  wire logic [2:0]         s_axi_awprot,        // Unused protection
   input  wire logic               s_axi_awvalid,       // Write address valid
   output var  logic               s_axi_awready,       // Write address ready
   input  wire logic [DATA_W-1:0]  s_axi_wdata,         // Write data
   input  wire logic [3:0]         s_axi_wstrb,         // Write byte strobes
   input  wire logic               s_axi_wvalid,        // Write data valid
   output var  logic               s_axi_wready,        // Write data ready
   output var  logic [1:0]         s_axi_bresp,         // Write response
   output var  logic               s_axi_bvalid,        // Write response valid
   input  wire logic               s_axi_bready,        // Write response ready
   input  wire logic [ADDR_W-1:0]  s_axi_araddr,        // Read address
   input  wire logic [2:0]         s_axi_arprot,        // Unused protection
   input  wire logic               s_axi_arvalid,       // Read address valid
   output var  logic               s_axi_arready,       // Read address ready
   output var  logic [DATA_W-1:0]  s_axi_rdata,         // Read data
   output var  logic [1:0]         s_axi_rresp,         // Read response
   output var  logic               s_axi_rvalid,        // Read data valid
   input  wire logic               s_axi_rready         // Read data ready
);

   tlic_state_type q;
   tlic_state_type d;

   logic [NUM_SRC-1:0] prio_eff;
   logic [NUM_SRC-1:0] armed;
   logic [NUM_SRC-1:0] hi_elig;
   logic [NUM_SRC-1:0] lo_elig;
   logic [NUM_SRC-1:0] wmask;
   logic [NUM_SRC-1:0] wval;
   logic               taken;
   logic [DATA_W-1:0]  rd_word;
   logic               rd_hit;

   // ----------------------------------------------------------------------
   // Arbitration
   // ----------------------------------------------------------------------
   always_comb
   begin
      prio_eff = q.prio | EXT_ZERO_MASK;
      armed    = q.flag & q.en;
      if (!q.mode)
      begin
         // Priority bits are ignored; everything is treated as one level.
         hi_elig = armed & (~PERIPH_MASK | {NUM_SRC{q.gl}})
                   & {NUM_SRC{q.gh}};
         lo_elig = '0;
      end
      else
      begin
         hi_elig = armed & prio_eff & {NUM_SRC{q.gh}};
         lo_elig = armed & ~prio_eff & {NUM_SRC{q.gh & q.gl}}
                   & {NUM_SRC{~q.high_act}};
      end
   end

   // ----------------------------------------------------------------------
   // Register read decode
   // ----------------------------------------------------------------------
   always_comb
   begin
      rd_word = '0;
      rd_hit  = 1'b1;
      unique case (s_axi_araddr)
         CONTROL_OFS:
         begin
            rd_word[CTL_MODE_BIT] = q.mode;
            rd_word[CTL_GH_BIT]   = q.gh;
            rd_word[CTL_GL_BIT]   = q.gl;
         end
         FLAG_OFS:     rd_word[NUM_SRC-1:0] = q.flag;
         ENABLE_OFS:   rd_word[NUM_SRC-1:0] = q.en;
         PRIORITY_OFS: rd_word[NUM_SRC-1:0] = prio_eff;
         STATUS_OFS:
         begin
            rd_word[STS_HIGH_ACT_BIT]         = q.high_act;
            rd_word[STS_LOW_ACT_BIT]          = q.low_act;
            rd_word[STS_REQ_BIT]              = q.req;
            rd_word[STS_VEC_LSB +: 16]        = q.vector;
         end
         default:      rd_hit = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      d     = q;
      wmask = {{8{q.wstrb[1]}}, {8{q.wstrb[0]}}};
      wval  = q.wdata[NUM_SRC-1:0];
      taken = irq_ack & q.req;

      // Write channel: address and data are taken independently.
      if (s_axi_awvalid && q.awready)
      begin
         d.aw_got  = 1'b1;
         d.awaddr  = s_axi_awaddr;
         d.awready = 1'b0;
      end
      if (s_axi_wvalid && q.wready)
      begin
         d.w_got  = 1'b1;
         d.wdata  = s_axi_wdata;
         d.wstrb  = s_axi_wstrb;
         d.wready = 1'b0;
      end
      if (q.bvalid && s_axi_bready)
      begin
         d.bvalid  = 1'b0;
         d.awready = 1'b1;
         d.wready  = 1'b1;
      end

      // Software writes land first, so a hardware response in the same cycle wins.
      if (q.aw_got && q.w_got && !q.bvalid)
      begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = RESP_OKAY;
         unique case (q.awaddr)
            CONTROL_OFS:
            begin
               if (q.wstrb[0])
               begin
                  d.mode = q.wdata[CTL_MODE_BIT];
                  d.gh   = q.wdata[CTL_GH_BIT];
                  d.gl   = q.wdata[CTL_GL_BIT];
               end
            end
            FLAG_OFS:     d.flag = q.flag & ~(wmask & wval);
            ENABLE_OFS:   d.en   = (q.en & ~wmask) | (wval & wmask);
            PRIORITY_OFS: d.prio = ((q.prio & ~wmask) | (wval & wmask)) | EXT_ZERO_MASK;
            STATUS_OFS:   d.bresp = RESP_OKAY;
            default:      d.bresp = RESP_SLVERR;
         endcase
      end

      // An event in the clearing cycle is kept.
      d.flag = d.flag | src_event;

      // Read channel.
      if (s_axi_arvalid && q.arready)
      begin
         d.arready = 1'b0;
         d.rvalid  = 1'b1;
         d.rdata   = rd_word;
         d.rresp   = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (q.rvalid && s_axi_rready)
      begin
         d.rvalid  = 1'b0;
         d.arready = 1'b1;
      end

      // Handler return re-opens the level that was in service.
      if (return_from_handler)
      begin
         if (!q.mode || q.high_act)
         begin
            d.gh       = 1'b1;
            d.high_act = 1'b0;
         end
         else
         begin
            d.gl      = 1'b1;
            d.low_act = 1'b0;
         end
      end

      // Taking the vector closes its level.
      if (taken)
      begin
         if (!q.mode || q.vec_high)
         begin
            d.gh       = 1'b0;
            d.high_act = 1'b1;
         end
         else
         begin
            d.gl      = 1'b0;
            d.low_act = 1'b1;
         end
      end

      // The request drops in the cycle after it is taken so one event cannot
      // be taken twice before the cleared gh or gl bit of its level is seen.
      d.req      = ((|hi_elig) | (|lo_elig)) & ~taken;
      d.vec_high = (|hi_elig) | ~q.mode;
      d.vector   = d.vec_high ? HIGH_VECTOR : LOW_VECTOR;
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         q          <= '0;
         q.mode     <= 1'b0;
         q.flag     <= FLAG_RST;
         q.en       <= ENABLE_RST;
         q.prio     <= PRIORITY_RST;
         q.vec_high <= 1'b1;
         q.vector   <= HIGH_VECTOR;
         q.awready  <= 1'b1;
         q.wready   <= 1'b1;
         q.arready  <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign irq_request    = q.req;
   assign irq_vector     = q.vector;
   assign irq_level_high = q.vec_high;
   assign s_axi_awready  = q.awready;
   assign s_axi_wready   = q.wready;
   assign s_axi_bresp    = q.bresp;
   assign s_axi_bvalid   = q.bvalid;
   assign s_axi_arready  = q.arready;
   assign s_axi_rdata    = q.rdata;
   assign s_axi_rresp    = q.rresp;
   assign s_axi_rvalid   = q.rvalid;

endmodule

`default_nettype wire

// ===== verification/tlic_core_properties.sv
// Concurrent checks on the ports of the interrupt controller.
// Assumes the single clock aclk and the synchronous active-low reset aresetn.
`timescale 1ns/1ps
`default_nettype none
module tlic_core_properties
   import tlic_pkg::*;
(
   input wire logic        aclk,           // Clock
   input wire logic        aresetn,        // Reset, low
   input wire logic        irq_ack,        // Core takes vector
   input wire logic        irq_request,    // Branch request
   input wire logic [15:0] irq_vector,     // Vector address
   input wire logic        irq_level_high, // Request level
   input wire logic        s_axi_awvalid,  // AW valid
   input wire logic        s_axi_awready,  // AW ready
   input wire logic        s_axi_wvalid,   // W valid
   input wire logic        s_axi_wready,   // W ready
   input wire logic [1:0]  s_axi_bresp,    // B response
   input wire logic        s_axi_bvalid,   // B valid
   input wire logic        s_axi_bready,   // B ready
   input wire logic        s_axi_arvalid,  // AR valid
   input wire logic        s_axi_arready,  // AR ready
   input wire logic [31:0] s_axi_rdata,    // R data
   input wire logic        s_axi_rvalid,   // R valid
   input wire logic        s_axi_rready    // R ready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   vector_map_a: assert property (irq_request |->
      irq_vector == (irq_level_high ? HIGH_VECTOR : LOW_VECTOR)) else $error("vector off level");
   ack_drop_a: assert property (irq_ack && irq_request |=> !irq_request)
      else $error("request stays after ack");
   reset_idle_a: assert property (disable iff (1'b0)
      !aresetn |=> !irq_request && irq_level_high && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs not idle after reset");
   write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |=> ##1 s_axi_bvalid) else $error("no write response");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   read_data_a: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready) else $error("no read data");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   ready_low_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("ready during response");
   low_taken_c: cover property (irq_ack && irq_request && !irq_level_high);
   high_taken_c: cover property (irq_ack && irq_request && irq_level_high);
   slverr_c: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
bind tlic_core tlic_core_properties tlic_core_properties_inst (.aclk, .aresetn, .irq_ack,
   .irq_request, .irq_vector, .irq_level_high, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ===== verification/tlic_core_model.sv
// Behavioural model of the core branch logic that faces the controller.
// Assumes the bench commands handler returns through ret_go.
`timescale 1ns/1ps
`default_nettype none
module tlic_core_model
(
   input  wire logic        aclk,                // Clock
   input  wire logic        aresetn,             // Reset, low
   input  wire logic        irq_request,         // Branch request
   input  wire logic [15:0] irq_vector,          // Vector
   input  wire logic        auto_on,             // Take requests
   input  wire logic [3:0]  ack_dly,             // Wait before taking
   input  wire logic        ret_go,              // Leave handler
   output logic             irq_ack,             // Vector taken
   output logic             return_from_handler, // Handler return
   output logic [7:0]       n_taken,             // Vectors taken
   output logic [15:0]      last_vec             // Last vector taken
);
   logic [3:0] wait_q;
   // The wait lets the bench make the core prompt or slow.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_ack             <= 1'b0;
         return_from_handler <= 1'b0;
         wait_q              <= 4'h0;
         n_taken             <= 8'h00;
         last_vec            <= 16'h0000;
      end
      else
      begin
         irq_ack             <= 1'b0;
         return_from_handler <= ret_go;
         wait_q              <= 4'h0;
         if (auto_on && irq_request && !irq_ack)
         begin
            wait_q <= wait_q + 4'h1;
            if (wait_q >= ack_dly)
            begin
               irq_ack  <= 1'b1;
               wait_q   <= 4'h0;
               n_taken  <= n_taken + 8'h01;
               last_vec <= irq_vector;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== verification/two_level_interrupt_controller_tb.sv
// Self-checking bench: register bus master, event stimulus and a core model.
// Assumes the package, the design, the core model and the checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module two_level_interrupt_controller_tb
   import tlic_pkg::*;
;
   logic        aclk, aresetn, irq_ack, return_from_handler, irq_request, irq_level_high;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        auto_on, ret_go;
   logic [15:0] src_event, irq_vector, last_vec;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, n_taken;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  ack_dly;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          fails, checks_done, m_ctl, m_en, m_prio, m_flag, r;
   tlic_core tlic_core_inst (.aclk, .aresetn, .src_event, .irq_ack, .return_from_handler,
      .irq_request, .irq_vector, .irq_level_high, .s_axi_awaddr, .s_axi_awprot(3'h0),
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   tlic_core_model tlic_core_model_inst (.aclk, .aresetn, .irq_request, .irq_vector,
      .auto_on, .ack_dly, .ret_go, .irq_ack, .return_from_handler, .n_taken, .last_vec);
   initial
   begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   // ------------------------------------------------------------------
   // Checking and bus tasks.
   // ------------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic give_up();
      fails++;
      close_out();
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
      // A late bready makes the slave hold its response for a while.
      s_axi_bready <= 1'($urandom_range(1, 0));
      for (int i = 0; i <= 50; i++)
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bready <= 1'b0;
            chk(32'(s_axi_bresp), a > STATUS_OFS ? RESP_SLVERR : RESP_OKAY);
            break;
         end
         if (s_axi_bvalid) s_axi_bready <= 1'b1;
         if (i == 50) give_up();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      // A late rready makes the slave hold its read data for a while.
      s_axi_rready <= 1'($urandom_range(1, 0));
      for (int i = 0; i <= 50; i++)
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rready <= 1'b0;
            chk(32'(s_axi_rresp), a > STATUS_OFS ? RESP_SLVERR : RESP_OKAY);
            chk(s_axi_rdata & m, e);
            break;
         end
         if (s_axi_rvalid) s_axi_rready <= 1'b1;
         if (i == 50) give_up();
      end
   endtask
   task automatic pulse(input logic [15:0] ev);
      @(posedge aclk);
      src_event <= ev;
      @(posedge aclk);
      src_event <= 16'h0000;
      repeat (3) @(posedge aclk);
   endtask
   task automatic taken(input logic [7:0] n, input logic [15:0] v);
      for (int i = 0; n_taken !== n; i++)
      begin
         @(posedge aclk);
         if (i == 40) give_up();
      end
      chk(32'(last_vec), 32'(v));
   endtask
   task automatic leave();
      @(posedge aclk);
      ret_go <= 1'b1;
      @(posedge aclk);
      ret_go <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask
   // Expected {request, high} from the model registers.
   function automatic int predict();
      int fe;
      fe = m_flag & m_en;
      if (m_ctl[0] == 1'b0)
         return (m_ctl[1] && ((fe & ~PERIPH_MASK) != 0 || (m_ctl[2] && (fe & PERIPH_MASK) != 0)))
            ? 3 : 1;
      if (m_ctl[1] && (fe & (m_prio | 1)) != 0) return 3;
      return (m_ctl[1] && m_ctl[2] && (fe & ~(m_prio | 1)) != 0) ? 2 : 0;
   endfunction
   // ------------------------------------------------------------------
   // Main sequence.
   // ------------------------------------------------------------------
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, auto_on, ret_go, src_event, s_axi_awaddr, s_axi_araddr} = '0;
      {s_axi_wdata, fails, checks_done} = '0;
      void'($urandom(11228));
      ack_dly = 4'($urandom_range(3, 0));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(CONTROL_OFS, 32'h0, 32'hFFFFFFFF);
      rd(PRIORITY_OFS, 32'hFFFF, 32'hFFFF);
      rd(8'h14, 32'h0, 32'hFFFFFFFF);
      wr(8'h14, 32'hFFFFFFFF);
      wr(STATUS_OFS, 32'hFFFFFFFF);
      rd(STATUS_OFS, {HIGH_VECTOR, 16'h0000}, 32'hFFFFFFFF);
      // Flags are cleared first so an old request cannot leak into the next trial.
      for (int t = 0; t < 48; t++)
      begin
         wr(FLAG_OFS, 32'hFFFF);
         m_prio = $urandom & 16'hFFFF;
         m_en = $urandom & 16'hFFFF;
         m_ctl = $urandom & 7;
         m_flag = $urandom & 16'hFFFF;
         wr(PRIORITY_OFS, m_prio);
         wr(ENABLE_OFS, m_en);
         wr(CONTROL_OFS, m_ctl);
         pulse(16'(m_flag));
         r = predict();
         chk(32'(irq_request), 32'(r[1]));
         if (r[1]) chk(32'(irq_vector), r[0] ? 32'h0008 : 32'h0018);
         if (r[1]) chk(32'(irq_level_high), 32'(r[0]));
         rd(FLAG_OFS, m_flag, 32'hFFFF);
         rd(PRIORITY_OFS, m_prio | 1, 32'hFFFF);
      end
      wr(FLAG_OFS, 32'hFFFF);
      wr(PRIORITY_OFS, 32'h0000);
      wr(ENABLE_OFS, 32'h0061);
      wr(CONTROL_OFS, 32'h7);
      auto_on <= 1'b1;
      pulse(16'h0020);
      taken(8'h01, 16'h0018);
      rd(CONTROL_OFS, 32'h3, 32'h7);
      wr(FLAG_OFS, 32'h0020);
      pulse(16'h0001);
      taken(8'h02, 16'h0008);
      rd(CONTROL_OFS, 32'h1, 32'h7);
      wr(FLAG_OFS, 32'h0001);
      wr(CONTROL_OFS, 32'h7);
      pulse(16'h0040);
      chk(32'(irq_request), 32'h0);
      rd(STATUS_OFS, 32'h3, 32'h7);
      leave();
      taken(8'h03, 16'h0018);
      wr(FLAG_OFS, 32'h0040);
      leave();
      rd(CONTROL_OFS, 32'h7, 32'h7);
      close_out();
   end
endmodule
`default_nettype wire
